// File: verilog/imc_regs.vh
// register map, field positions and reset values of the interrupt mask controller
`ifndef IMC_REGS_VH
`define IMC_REGS_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define IMC_ADDR_ENABLED_REQUEST_STATUS 32'hFFFF0000
`define IMC_ADDR_RAW_SOURCE_STATUS 32'hFFFF0004
`define IMC_ADDR_SOURCE_ENABLE_MASK 32'hFFFF0008
`define IMC_ADDR_ENABLE_MASK_CLEAR 32'hFFFF000C
`define IMC_ADDR_SOFTWARE_REQUEST 32'hFFFF0030
`define IMC_ADDR_VECTOR_CONFIG 32'hFFFF0034
`define IMC_ADDR_FAST_ENABLED_STATUS 32'hFFFF0100
`define IMC_ADDR_FAST_RAW_STATUS 32'hFFFF0104
`define IMC_ADDR_FAST_ENABLE_MASK 32'hFFFF0108
`define IMC_ADDR_FAST_ENABLE_CLEAR 32'hFFFF010C

// ****************************************************************
// source vector layout
// ****************************************************************
`define IMC_SRC_FAST_SUMMARY 0
`define IMC_SRC_SOFTWARE 1
`define IMC_SRC_TIMER_LO 2
`define IMC_SRC_TIMER_HI 6
`define IMC_SRC_CURRENT_DAC 7
`define IMC_SRC_SUPPLY_MONITOR 8
`define IMC_SRC_UNUSED 9
`define IMC_SRC_FLASH_LO 10
`define IMC_SRC_FLASH_HI 11
`define IMC_SRC_ADC 12
`define IMC_SRC_UART 13
`define IMC_SRC_SPI 14
`define IMC_SRC_I2C_LO 15
`define IMC_SRC_I2C_HI 18
`define IMC_SRC_EXT_LO 19
`define IMC_SRC_EXT_HI 22
`define IMC_SRC_PWM_TRIP 23
`define IMC_SRC_EXT4 24
`define IMC_SRC_EXT5 25
`define IMC_SRC_PLA_LO 26
`define IMC_SRC_PLA_HI 27
`define IMC_SRC_TOP 27

// ****************************************************************
// masks, fields and reset values
// ****************************************************************
`define IMC_VALID_MASK 32'h0FFFFFFF
`define IMC_SW_NORMAL_BIT 1
`define IMC_SW_FAST_BIT 2
`define IMC_SW_MASK 32'h00000006
`define IMC_NEST_NORMAL_BIT 0
`define IMC_NEST_FAST_BIT 1
`define IMC_VCFG_MASK 32'h00000003
`define IMC_RESET_WORD 32'h00000000

`endif

// File: verilog/imc_sync.v
// two-flop level synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ps

module imc_sync #(
  parameter WIDTH = 6
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // levels
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  // ****************************************************************
  // first stage feeds only the second
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1 <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// File: verilog/imc_ctrl.v
// normal and fast interrupt mask and status controller with apb register access
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "imc_regs.vh"

module imc_ctrl (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // on-chip peripheral requests, same clock
  input wire [4:0] timer_req,
  input wire current_dac_req,
  input wire supply_monitor_req,
  input wire [1:0] flash_req,
  input wire adc_req,
  input wire uart_req,
  input wire spi_req,
  input wire [3:0] i2c_req,
  input wire pwm_trip_req,
  input wire [1:0] programmable_logic_array_req,
  // external pin requests, asynchronous
  input wire [5:0] external_pin_request,
  // requests to the core
  output reg normal_irq,
  output reg fast_irq,
  // vectored extension configuration
  output reg nest_enable,
  output reg fast_nest_enable
);

  // ****************************************************************
  // state
  // ****************************************************************
  reg [31:0] raw_source_status;
  reg [31:0] fast_raw_status;
  reg [31:0] source_enable_mask;
  reg [31:0] fast_enable_mask;
  reg [31:0] software_request;
  wire [5:0] pin_sync;
  wire [31:0] enabled_request_status;
  wire [31:0] fast_enabled_status;

  // ****************************************************************
  // external pins through two flops
  // ****************************************************************
  imc_sync #(
    .WIDTH(6)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(external_pin_request),
    .sync_out(pin_sync)
  );

  // ****************************************************************
  // peripheral source vector
  // ****************************************************************
  reg [31:0] periph_vec;

  always @*
  begin
    periph_vec = 32'h00000000;
    periph_vec[`IMC_SRC_TIMER_HI:`IMC_SRC_TIMER_LO] = timer_req;
    periph_vec[`IMC_SRC_CURRENT_DAC] = current_dac_req;
    periph_vec[`IMC_SRC_SUPPLY_MONITOR] = supply_monitor_req;
    periph_vec[`IMC_SRC_UNUSED] = 1'b0;
    periph_vec[`IMC_SRC_FLASH_HI:`IMC_SRC_FLASH_LO] = flash_req;
    periph_vec[`IMC_SRC_ADC] = adc_req;
    periph_vec[`IMC_SRC_UART] = uart_req;
    periph_vec[`IMC_SRC_SPI] = spi_req;
    periph_vec[`IMC_SRC_I2C_HI:`IMC_SRC_I2C_LO] = i2c_req;
    periph_vec[`IMC_SRC_EXT_HI:`IMC_SRC_EXT_LO] = pin_sync[3:0];
    periph_vec[`IMC_SRC_PWM_TRIP] = pwm_trip_req;
    periph_vec[`IMC_SRC_EXT4] = pin_sync[4];
    periph_vec[`IMC_SRC_EXT5] = pin_sync[5];
    periph_vec[`IMC_SRC_PLA_HI:`IMC_SRC_PLA_LO] = programmable_logic_array_req;
  end

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire setup_phase;
  wire wr_commit;
  reg addr_hit;

  assign setup_phase = psel & ~penable;
  assign wr_commit = psel & penable & pready & pwrite & ~pslverr;

  always @*
  begin
    case (paddr)
      `IMC_ADDR_ENABLED_REQUEST_STATUS,
      `IMC_ADDR_RAW_SOURCE_STATUS,
      `IMC_ADDR_SOURCE_ENABLE_MASK,
      `IMC_ADDR_ENABLE_MASK_CLEAR,
      `IMC_ADDR_SOFTWARE_REQUEST,
      `IMC_ADDR_VECTOR_CONFIG,
      `IMC_ADDR_FAST_ENABLED_STATUS,
      `IMC_ADDR_FAST_RAW_STATUS,
      `IMC_ADDR_FAST_ENABLE_MASK,
      `IMC_ADDR_FAST_ENABLE_CLEAR:
        addr_hit = 1'b1;
      default:
        addr_hit = 1'b0;
    endcase
  end

  wire wr_en_set;
  wire wr_en_clr;
  wire wr_fen_set;
  wire wr_fen_clr;
  wire wr_swi;
  wire wr_vcfg;

  assign wr_en_set = wr_commit & (paddr == `IMC_ADDR_SOURCE_ENABLE_MASK);
  assign wr_en_clr = wr_commit & (paddr == `IMC_ADDR_ENABLE_MASK_CLEAR);
  assign wr_fen_set = wr_commit & (paddr == `IMC_ADDR_FAST_ENABLE_MASK);
  assign wr_fen_clr = wr_commit & (paddr == `IMC_ADDR_FAST_ENABLE_CLEAR);
  assign wr_swi = wr_commit & (paddr == `IMC_ADDR_SOFTWARE_REQUEST);
  assign wr_vcfg = wr_commit & (paddr == `IMC_ADDR_VECTOR_CONFIG);

  // ****************************************************************
  // next enable masks
  // ****************************************************************
  wire [31:0] wdata_valid;
  reg [31:0] next_source_enable_mask;
  reg [31:0] next_fast_enable_mask;
  reg [31:0] next_software_request;

  assign wdata_valid = pwdata & `IMC_VALID_MASK;

  always @*
  begin
    next_source_enable_mask = source_enable_mask;
    next_fast_enable_mask = fast_enable_mask;
    if (wr_en_set)
    begin
      next_source_enable_mask = source_enable_mask | wdata_valid;
      next_fast_enable_mask = fast_enable_mask & ~wdata_valid;
    end
    if (wr_en_clr)
      next_source_enable_mask = source_enable_mask & ~wdata_valid;
    if (wr_fen_set)
    begin
      next_fast_enable_mask = fast_enable_mask | wdata_valid;
      next_source_enable_mask = source_enable_mask & ~wdata_valid;
    end
    if (wr_fen_clr)
      next_fast_enable_mask = fast_enable_mask & ~wdata_valid;
  end

  always @*
  begin
    next_software_request = software_request;
    if (wr_swi)
      next_software_request = pwdata & `IMC_SW_MASK;
  end

  // ****************************************************************
  // next raw vectors and fast summary
  // ****************************************************************
  reg [31:0] next_raw_source_status;
  reg [31:0] next_fast_raw_status;
  wire next_fast_summary;

  always @*
  begin
    next_fast_raw_status = periph_vec;
    next_fast_raw_status[`IMC_SRC_SOFTWARE] = next_software_request[`IMC_SW_FAST_BIT];
    next_fast_raw_status[`IMC_SRC_FAST_SUMMARY] = next_fast_summary;
    next_raw_source_status = periph_vec;
    next_raw_source_status[`IMC_SRC_SOFTWARE] =
      next_software_request[`IMC_SW_NORMAL_BIT];
    next_raw_source_status[`IMC_SRC_FAST_SUMMARY] = next_fast_summary;
  end

  // summary excludes bit 0, so no loop through the fast mask
  assign next_fast_summary = |(periph_vec[31:1] & next_fast_enable_mask[31:1]) |
    (next_software_request[`IMC_SW_FAST_BIT] & next_fast_enable_mask[`IMC_SRC_SOFTWARE]);

  wire [31:0] next_enabled;
  wire [31:0] next_fast_enabled;

  assign next_enabled = next_raw_source_status & next_source_enable_mask;
  assign next_fast_enabled = next_fast_raw_status & next_fast_enable_mask;

  // ****************************************************************
  // status and mask registers
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      raw_source_status <= `IMC_RESET_WORD;
      fast_raw_status <= `IMC_RESET_WORD;
      source_enable_mask <= `IMC_RESET_WORD;
      fast_enable_mask <= `IMC_RESET_WORD;
      software_request <= `IMC_RESET_WORD;
    end
    else
    begin
      raw_source_status <= next_raw_source_status & `IMC_VALID_MASK;
      fast_raw_status <= next_fast_raw_status & `IMC_VALID_MASK;
      source_enable_mask <= next_source_enable_mask;
      fast_enable_mask <= next_fast_enable_mask;
      software_request <= next_software_request;
    end
  end

  assign enabled_request_status = raw_source_status & source_enable_mask;
  assign fast_enabled_status = fast_raw_status & fast_enable_mask;

  // ****************************************************************
  // requests to the core
  // ****************************************************************
  // plain or, no encoder: the handler scans the status word
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      normal_irq <= 1'b0;
      fast_irq <= 1'b0;
    end
    else
    begin
      normal_irq <= |next_enabled;
      fast_irq <= |next_fast_enabled[31:1];
    end
  end

  // ****************************************************************
  // vectored extension configuration
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nest_enable <= 1'b0;
      fast_nest_enable <= 1'b0;
    end
    else if (wr_vcfg)
    begin
      nest_enable <= pwdata[`IMC_NEST_NORMAL_BIT];
      fast_nest_enable <= pwdata[`IMC_NEST_FAST_BIT];
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  reg [31:0] rd_mux;

  always @*
  begin
    case (paddr)
      `IMC_ADDR_ENABLED_REQUEST_STATUS:
        rd_mux = enabled_request_status;
      `IMC_ADDR_RAW_SOURCE_STATUS:
        rd_mux = raw_source_status;
      `IMC_ADDR_SOURCE_ENABLE_MASK:
        rd_mux = source_enable_mask;
      `IMC_ADDR_SOFTWARE_REQUEST:
        rd_mux = software_request;
      `IMC_ADDR_VECTOR_CONFIG:
        rd_mux = {30'h00000000, fast_nest_enable, nest_enable};
      `IMC_ADDR_FAST_ENABLED_STATUS:
        rd_mux = fast_enabled_status;
      `IMC_ADDR_FAST_RAW_STATUS:
        rd_mux = fast_raw_status;
      `IMC_ADDR_FAST_ENABLE_MASK:
        rd_mux = fast_enable_mask;
      default:
        rd_mux = 32'h00000000;
    endcase
  end

  // ****************************************************************
  // apb handshake: answer in the first access cycle
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (setup_phase)
    begin
      pready <= 1'b1;
      pslverr <= ~addr_hit;
      prdata <= pwrite ? 32'h00000000 : rd_mux;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end

endmodule

// File: testbench/imc_src_model.sv
// source request model standing in for the peripherals and pins
`timescale 1ns/1ps

module imc_src_model (
  // source levels indexed by source bit
  input wire [27:0] lvl,
  // peripheral and pin requests
  output wire [4:0] timer_req,
  output wire current_dac_req,
  output wire supply_monitor_req,
  output wire [1:0] flash_req,
  output wire adc_req,
  output wire uart_req,
  output wire spi_req,
  output wire [3:0] i2c_req,
  output wire pwm_trip_req,
  output wire [1:0] programmable_logic_array_req,
  output wire [5:0] external_pin_request
);
  assign timer_req = lvl[6:2];
  assign current_dac_req = lvl[7];
  assign supply_monitor_req = lvl[8];
  assign flash_req = lvl[11:10];
  assign adc_req = lvl[12];
  assign uart_req = lvl[13];
  assign spi_req = lvl[14];
  assign i2c_req = lvl[18:15];
  assign pwm_trip_req = lvl[23];
  assign programmable_logic_array_req = lvl[27:26];
  assign external_pin_request = {lvl[25:24], lvl[22:19]};
endmodule

// File: testbench/imc_ctrl_monitor.sv
// port-level assertions for the interrupt mask controller
`timescale 1ns/1ps
`include "imc_regs.vh"

module imc_ctrl_monitor (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // sources
  input wire [4:0] timer_req,
  input wire current_dac_req,
  input wire supply_monitor_req,
  input wire [1:0] flash_req,
  input wire adc_req,
  input wire uart_req,
  input wire spi_req,
  input wire [3:0] i2c_req,
  input wire pwm_trip_req,
  input wire [1:0] programmable_logic_array_req,
  input wire [5:0] external_pin_request,
  // outputs
  input wire normal_irq,
  input wire fast_irq,
  input wire nest_enable,
  input wire fast_nest_enable
);
  wire wr_acc = psel && penable && pready && pwrite;
  wire src_any = |{timer_req, current_dac_req, supply_monitor_req, flash_req, adc_req,
    uart_req, spi_req, i2c_req, pwm_trip_req, programmable_logic_array_req};
  wire pin_any = |external_pin_request;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside access cycle");
  AST_RDATA_IDLE_ZERO: assert property (!pready |-> prdata == 32'h00000000)
    else $error("prdata nonzero outside access");
  AST_TOP_BITS_ZERO: assert property (pready && !pwrite |-> prdata[31:28] == 4'h0)
    else $error("read data bits 31 to 28 set");
  AST_IRQ_HAS_CAUSE: assert property ($rose(normal_irq) |->
    $past(src_any) || $past(pin_any) || $past(wr_acc))
    else $error("normal_irq rose without cause");
  AST_FAST_HAS_CAUSE: assert property ($rose(fast_irq) |->
    $past(src_any) || $past(pin_any) || $past(wr_acc))
    else $error("fast_irq rose without cause");
  AST_NEST_BY_WRITE: assert property ($changed({nest_enable, fast_nest_enable}) |->
    $past(wr_acc && paddr == `IMC_ADDR_VECTOR_CONFIG))
    else $error("nest enables changed without write");

  cover property ($rose(normal_irq));
  cover property ($rose(fast_irq));
  cover property (pslverr);
endmodule

bind imc_ctrl imc_ctrl_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .timer_req, .current_dac_req, .supply_monitor_req,
  .flash_req, .adc_req, .uart_req, .spi_req, .i2c_req, .pwm_trip_req,
  .programmable_logic_array_req, .external_pin_request, .normal_irq, .fast_irq,
  .nest_enable, .fast_nest_enable);

// File: testbench/irq_mask_status_controller_test.sv
// self-checking bench for the interrupt mask controller
`timescale 1ns/1ps
`include "imc_regs.vh"

module irq_mask_status_controller_test;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [31:0] paddr = 32'h00000000;
  reg [31:0] pwdata = 32'h00000000;
  reg [27:0] lvl = 28'h0000000;
  wire [31:0] prdata;
  wire pready, pslverr, normal_irq, fast_irq, nest_enable, fast_nest_enable;
  wire [4:0] timer_req;
  wire [1:0] flash_req, programmable_logic_array_req;
  wire [3:0] i2c_req;
  wire [5:0] external_pin_request;
  wire current_dac_req, supply_monitor_req, adc_req, uart_req, spi_req, pwm_trip_req;
  integer fails = 0;
  integer checked = 0;
  integer seed, b, i;
  reg [31:0] m, e;
  logic [32:0] expq[$];
  logic [32:0] q;

  imc_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .timer_req, .current_dac_req, .supply_monitor_req, .flash_req,
    .adc_req, .uart_req, .spi_req, .i2c_req, .pwm_trip_req, .programmable_logic_array_req,
    .external_pin_request, .normal_irq, .fast_irq, .nest_enable, .fast_nest_enable);

  imc_src_model u_src (.lvl, .timer_req, .current_dac_req, .supply_monitor_req, .flash_req,
    .adc_req, .uart_req, .spi_req, .i2c_req, .pwm_trip_req, .programmable_logic_array_req,
    .external_pin_request);

  initial
  begin
    forever #12.5 pclk = ~pclk;
  end

  // ****************
  // checks and bus tasks
  // ****************
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    begin
      checked = checked + 1;
      if (got !== ex)
      begin
        fails = fails + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, ex, got);
      end
    end
  endtask

  task xfer(input w, input [31:0] a, input [31:0] d, input er, input [31:0] x);
    integer n;
    begin
      n = 0;
      expq.push_back({er, x});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
        @(posedge pclk);
        n = n + 1;
      end
      if (n == 20)
        fails = fails + 1;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task rd(input [31:0] a, input [31:0] x);
    xfer(1'b0, a, 32'h00000000, 1'b0, x);
  endtask

  task wr(input [31:0] a, input [31:0] d);
    xfer(1'b1, a, d, 1'b0, 32'h00000000);
  endtask

  task chk_pin(input string nm, input logic ex, input logic got);
    begin
      @(negedge pclk);
      chk(nm, {31'h0, ex}, {31'h0, got});
      @(posedge pclk);
    end
  endtask

  // completed transfers against the oldest note
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
    begin
      q = (expq.size() > 0) ? expq.pop_front() : 33'h1FFFFFFFF;
      chk("pslverr", {31'h0, q[32]}, {31'h0, pslverr});
      if (!pwrite)
        chk("prdata", q[31:0], prdata);
    end

  task test_done;
    begin
      if (fails == 0 && checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  initial
  begin
    #(25 * 20000);
    fails = fails + 1;
    test_done;
  end

  // ****************
  // main sequence
  // ****************
  initial
  begin
    seed = 32'h4d6550a0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`IMC_ADDR_ENABLED_REQUEST_STATUS, 32'h00000000);
    rd(`IMC_ADDR_RAW_SOURCE_STATUS, 32'h00000000);
    rd(`IMC_ADDR_SOURCE_ENABLE_MASK, 32'h00000000);
    rd(`IMC_ADDR_ENABLE_MASK_CLEAR, 32'h00000000);
    xfer(1'b0, 32'hFFFF0200, 32'h00000000, 1'b1, 32'h00000000);
    xfer(1'b1, 32'hFFFF0040, 32'hFFFFFFFF, 1'b1, 32'h00000000);
    for (b = 2; b < 28; b = b + 1)
    begin
      m = (b == 9) ? 32'h00000000 : (32'h00000001 << b);
      lvl <= 28'h0000001 << b;
      repeat (4) @(posedge pclk);
      rd(`IMC_ADDR_RAW_SOURCE_STATUS, m);
      rd(`IMC_ADDR_ENABLED_REQUEST_STATUS, 32'h00000000);
      chk_pin("normal_irq", 1'b0, normal_irq);
      wr(`IMC_ADDR_SOURCE_ENABLE_MASK, 32'h00000001 << b);
      rd(`IMC_ADDR_ENABLED_REQUEST_STATUS, m);
      chk_pin("normal_irq", m != 0, normal_irq);
      // source quiet before its enable is cleared
      lvl <= 28'h0000000;
      repeat (3) @(posedge pclk);
      wr(`IMC_ADDR_ENABLE_MASK_CLEAR, 32'h00000001 << b);
      lvl <= 28'h0000001 << b;
      repeat (4) @(posedge pclk);
      rd(`IMC_ADDR_ENABLED_REQUEST_STATUS, 32'h00000000);
      chk_pin("normal_irq", 1'b0, normal_irq);
      lvl <= 28'h0000000;
      @(posedge pclk);
    end
    wr(`IMC_ADDR_SOURCE_ENABLE_MASK, 32'h00000F00);
    wr(`IMC_ADDR_SOURCE_ENABLE_MASK, 32'h00000030);
    rd(`IMC_ADDR_SOURCE_ENABLE_MASK, 32'h00000F30);
    wr(`IMC_ADDR_SOURCE_ENABLE_MASK, 32'hFFFFFFFF);
    rd(`IMC_ADDR_SOURCE_ENABLE_MASK, 32'h0FFFFFFF);
    wr(`IMC_ADDR_ENABLE_MASK_CLEAR, 32'h00000100);
    rd(`IMC_ADDR_SOURCE_ENABLE_MASK, 32'h0FFFFEFF);
    wr(`IMC_ADDR_RAW_SOURCE_STATUS, 32'hFFFFFFFF);
    rd(`IMC_ADDR_RAW_SOURCE_STATUS, 32'h00000000);
    for (i = 0; i < 12; i = i + 1)
    begin
      e = $random(seed);
      m = $random(seed);
      lvl <= 28'h0000000;
      repeat (3) @(posedge pclk);
      wr(`IMC_ADDR_ENABLE_MASK_CLEAR, 32'hFFFFFFFF);
      lvl <= m[27:0];
      wr(`IMC_ADDR_SOURCE_ENABLE_MASK, e);
      m = m & e & 32'h0FFFFDFC;
      rd(`IMC_ADDR_ENABLED_REQUEST_STATUS, m);
      chk_pin("normal_irq", m != 0, normal_irq);
    end
    lvl <= 28'h0000000;
    repeat (3) @(posedge pclk);
    wr(`IMC_ADDR_ENABLE_MASK_CLEAR, 32'hFFFFFFFF);
    lvl <= 28'h0000008;
    wr(`IMC_ADDR_SOFTWARE_REQUEST, 32'h00000002);
    rd(`IMC_ADDR_RAW_SOURCE_STATUS, 32'h0000000A);
    wr(`IMC_ADDR_SOFTWARE_REQUEST, 32'h00000000);
    wr(`IMC_ADDR_FAST_ENABLE_MASK, 32'h00000008);
    chk_pin("fast_irq", 1'b1, fast_irq);
    rd(`IMC_ADDR_RAW_SOURCE_STATUS, 32'h00000009);
    rd(`IMC_ADDR_FAST_RAW_STATUS, 32'h00000009);
    rd(`IMC_ADDR_ENABLED_REQUEST_STATUS, 32'h00000000);
    rd(`IMC_ADDR_FAST_ENABLED_STATUS, 32'h00000008);
    wr(`IMC_ADDR_SOURCE_ENABLE_MASK, 32'h00000008);
    rd(`IMC_ADDR_FAST_ENABLE_MASK, 32'h00000000);
    chk_pin("fast_irq", 1'b0, fast_irq);
    chk_pin("normal_irq", 1'b1, normal_irq);
    wr(`IMC_ADDR_VECTOR_CONFIG, 32'h00000001);
    chk_pin("nest_enable", 1'b1, nest_enable);
    wr(`IMC_ADDR_VECTOR_CONFIG, 32'h00000002);
    chk_pin("fast_nest_enable", 1'b1, fast_nest_enable);
    rd(`IMC_ADDR_VECTOR_CONFIG, 32'h00000002);
    test_done;
  end
endmodule
